// File: core/arcr_defines.vh
// arcr_defines.vh: register offsets, field positions and reset values for
// the converter result and configuration register block.
// assumes inclusion by bare name from the design file under core/.
`ifndef ARCR_DEFINES_VH
`define ARCR_DEFINES_VH

// -----------------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------------
`define ARCR_OFF_RESULT_HIGH 4'h0
`define ARCR_OFF_RESULT_LOW 4'h1
`define ARCR_OFF_CMP_HIGH 4'h2
`define ARCR_OFF_CMP_LOW 4'h3
`define ARCR_OFF_CONFIG 4'h4
`define ARCR_OFF_PIN_LO 4'h5
`define ARCR_OFF_CONTROL 4'h6
`define ARCR_OFF_STATUS 4'h7

// -----------------------------------------------------------------
// configuration fields
// -----------------------------------------------------------------
`define ARCR_CFG_LOW_POWER 7
`define ARCR_CFG_DIV_HI 6
`define ARCR_CFG_DIV_LO 5
`define ARCR_CFG_LONG_SAMPLE 4
`define ARCR_CFG_MODE_HI 3
`define ARCR_CFG_MODE_LO 2
`define ARCR_CFG_CLK_HI 1
`define ARCR_CFG_CLK_LO 0

// -----------------------------------------------------------------
// control and status fields
// -----------------------------------------------------------------
`define ARCR_CTL_CMP_ENABLE 0
`define ARCR_CTL_CMP_GREATER 1
`define ARCR_CTL_IRQ_ENABLE 2
`define ARCR_STS_COMPLETE 0
`define ARCR_STS_VALID 1
`define ARCR_STS_INTERLOCK 2

// -----------------------------------------------------------------
// mode codes
// -----------------------------------------------------------------
`define ARCR_MODE_8 2'h0
`define ARCR_MODE_12 2'h1
`define ARCR_MODE_10 2'h2

// -----------------------------------------------------------------
// reset values and bus response codes
// -----------------------------------------------------------------
`define ARCR_RST_BYTE 8'h00
`define ARCR_RST_CTL 3'h0
`define ARCR_RESP_OKAY 2'h0
`define ARCR_RESP_SLVERR 2'h2

`endif

// File: core/arcr_regs.v
// arcr_regs.v: result, compare, configuration and pin control registers
// of a successive approximation converter, reached over AXI4-Lite.
// assumes the conversion core delivers a 12-bit result with a one-cycle
// done pulse; inputs are synchronous to aclk.
//
// Function
// - 12-bit: upper four high, lower eight low
// - 10-bit: two bits high, bits 11:10 zero
// - 8-bit: whole result low, bits 11:8 zero
// - update on completion unless compare fails
// - high read locks results until low read
// - conversions during lock are discarded
// - 8-bit mode has no read lock
// - mode change makes results invalid unless a result is stored in the same cycle
// - 12-bit compare uses four high bits
// - 10-bit compare uses compare bits 9:8
// - 8-bit compare ignores compare high
// - compare low eight bits in every mode
// - bit 7 selects low-power configuration
// - bits 6:5 divide clock by 1,2,4,8
// - bit 4 selects long sample time
// - bits 3:2 select 8/12/10-bit resolution
// - bits 1:0 select converter input clock
// - pin disable bit n frees channel n pin
// - compare active only when enabled
// - less-than, or greater-or-equal when selected
// - stored result sets complete flag, interrupt
//
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`include "arcr_defines.vh"

module arcr_regs (
    input wire aclk,
    input wire aresetn,
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [11:0] conv_result,
    input wire conv_done,
    output reg low_power_select,
    output reg [1:0] clock_divide_select,
    output reg long_sample_select,
    output reg [1:0] conv_mode,
    output reg [1:0] input_clock_select,
    output reg [7:0] analog_pin_disable_lo,
    output reg conversion_complete_flag,
    output reg completion_irq
);

    // -----------------------------------------------------------------
    // storage
    // -----------------------------------------------------------------
    reg [7:0] result_high;
    reg [7:0] result_low;
    reg [7:0] compare_value_high;
    reg [7:0] compare_value_low;
    reg compare_enable;
    reg compare_greater_select;
    reg completion_irq_enable;
    reg result_valid;
    reg read_lock;
    reg [3:0] aw_addr;
    reg aw_held;
    reg [7:0] w_byte;
    reg w_held;
    reg w_lane0;

    // register byte 0 of a write, lane 0 only
    function lane0_hit;
        input [3:0] addr;
        input [3:0] want;
        input [3:0] strb;
        begin
            lane0_hit = (addr == want) && strb[0];
        end
    endfunction

    // -----------------------------------------------------------------
    // compare and alignment
    // -----------------------------------------------------------------
    reg [11:0] aligned;
    reg [11:0] cmp_val;
    reg cmp_ok;
    reg store_now;
    always @* begin
        aligned = 12'h000;
        cmp_val = {compare_value_high[3:0], compare_value_low};
        case (conv_mode)
            `ARCR_MODE_12: begin
                aligned = conv_result;
            end
            `ARCR_MODE_10: begin
                aligned = {2'b00, conv_result[9:0]};
                cmp_val = {2'b00, compare_value_high[1:0],
                    compare_value_low};
            end
            default: begin
                aligned = {4'h0, conv_result[7:0]};
                cmp_val = {4'h0, compare_value_low};
            end
        endcase
        // 12-bit keeps the full four high bits
        if (compare_greater_select)
            cmp_ok = (aligned >= cmp_val);
        else
            cmp_ok = (aligned < cmp_val);
        // lock applies only outside 8-bit mode
        store_now = conv_done && (!compare_enable || cmp_ok)
            && !(read_lock && conv_mode != `ARCR_MODE_8);
    end

    // -----------------------------------------------------------------
    // bus handshake decode
    // -----------------------------------------------------------------
    wire aw_ok = aw_held | s_axi_awvalid;
    wire w_ok = w_held | s_axi_wvalid;
    wire [3:0] wa = aw_held ? aw_addr : s_axi_awaddr;
    wire [7:0] wd = w_held ? w_byte : s_axi_wdata[7:0];
    // a held byte keeps its own lane strobe so a masked write stays void
    wire [3:0] ws = w_held ? {3'h0, w_lane0} : s_axi_wstrb;
    wire do_write = aw_ok && w_ok && !s_axi_bvalid;
    wire do_read = s_axi_arvalid && s_axi_arready;
    wire cfg_wr = do_write && lane0_hit(wa, `ARCR_OFF_CONFIG, ws);
    // a mode change voids the stored results unless a result is stored in the same cycle
    wire mode_chg = cfg_wr &&
        wd[`ARCR_CFG_MODE_HI:`ARCR_CFG_MODE_LO] != conv_mode;

    // -----------------------------------------------------------------
    // write channel: address and data accepted in either order
    // -----------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ARCR_RESP_OKAY;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 4'h0;
            w_byte <= `ARCR_RST_BYTE;
            w_lane0 <= 1'b0;
        end else begin
            // ready pulses one cycle when a channel is taken
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            if (s_axi_awvalid && !aw_held && !s_axi_awready &&
                    !do_write) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && !w_held && !s_axi_wready && !do_write) begin
                w_held <= 1'b1;
                w_byte <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
                w_lane0 <= s_axi_wstrb[0];
                s_axi_wready <= 1'b1;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_awready <= !aw_held;
                s_axi_wready <= !w_held;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wa > `ARCR_OFF_STATUS) ?
                    `ARCR_RESP_SLVERR : `ARCR_RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // -----------------------------------------------------------------
    // software-written registers
    // -----------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            compare_value_high <= `ARCR_RST_BYTE;
            compare_value_low <= `ARCR_RST_BYTE;
            low_power_select <= 1'b0;
            clock_divide_select <= 2'h0;
            long_sample_select <= 1'b0;
            conv_mode <= `ARCR_MODE_8;
            input_clock_select <= 2'h0;
            analog_pin_disable_lo <= `ARCR_RST_BYTE;
            {completion_irq_enable, compare_greater_select,
                compare_enable} <= `ARCR_RST_CTL;
        end else if (do_write) begin
            if (lane0_hit(wa, `ARCR_OFF_CMP_HIGH, ws))
                compare_value_high <= {4'h0, wd[3:0]};
            if (lane0_hit(wa, `ARCR_OFF_CMP_LOW, ws))
                compare_value_low <= wd;
            if (cfg_wr) begin
                low_power_select <= wd[`ARCR_CFG_LOW_POWER];
                clock_divide_select <=
                    wd[`ARCR_CFG_DIV_HI:`ARCR_CFG_DIV_LO];
                long_sample_select <= wd[`ARCR_CFG_LONG_SAMPLE];
                conv_mode <=
                    wd[`ARCR_CFG_MODE_HI:`ARCR_CFG_MODE_LO];
                input_clock_select <=
                    wd[`ARCR_CFG_CLK_HI:`ARCR_CFG_CLK_LO];
            end
            // a set bit hands the channel pin to the analog input
            if (lane0_hit(wa, `ARCR_OFF_PIN_LO, ws))
                analog_pin_disable_lo <= wd;
            if (lane0_hit(wa, `ARCR_OFF_CONTROL, ws)) begin
                compare_enable <= wd[`ARCR_CTL_CMP_ENABLE];
                compare_greater_select <= wd[`ARCR_CTL_CMP_GREATER];
                completion_irq_enable <= wd[`ARCR_CTL_IRQ_ENABLE];
            end
        end
    end

    // -----------------------------------------------------------------
    // result capture, lock and completion flag
    // -----------------------------------------------------------------
    wire rd_high = do_read && s_axi_araddr == `ARCR_OFF_RESULT_HIGH;
    wire rd_low = do_read && s_axi_araddr == `ARCR_OFF_RESULT_LOW;
    always @(posedge aclk) begin
        if (!aresetn) begin
            result_high <= `ARCR_RST_BYTE;
            result_low <= `ARCR_RST_BYTE;
            result_valid <= 1'b0;
            read_lock <= 1'b0;
            conversion_complete_flag <= 1'b0;
            completion_irq <= 1'b0;
        end else begin
            if (store_now) begin
                result_high <= {4'h0, aligned[11:8]};
                result_low <= aligned[7:0];
                result_valid <= 1'b1;
            end else if (mode_chg) begin
                result_valid <= 1'b0;
            end
            // low read releases the lock; a high read in the same cycle
            // cannot happen since reads are one at a time
            if (rd_low)
                read_lock <= 1'b0;
            else if (rd_high && conv_mode != `ARCR_MODE_8)
                read_lock <= 1'b1;
            // set wins over the clear made by reading the low result
            if (store_now)
                conversion_complete_flag <= 1'b1;
            else if (rd_low)
                conversion_complete_flag <= 1'b0;
            completion_irq <= completion_irq_enable &&
                (store_now || (conversion_complete_flag && !rd_low));
        end
    end

    // -----------------------------------------------------------------
    // read channel: one cycle from address to data
    // -----------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `ARCR_RESP_OKAY;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready &&
                !s_axi_rvalid;
            if (do_read) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `ARCR_RESP_OKAY;
                case (s_axi_araddr)
                    `ARCR_OFF_RESULT_HIGH: s_axi_rdata <= {24'h0, result_high};
                    `ARCR_OFF_RESULT_LOW: s_axi_rdata <= {24'h0, result_low};
                    `ARCR_OFF_CMP_HIGH:
                        s_axi_rdata <= {24'h0, compare_value_high};
                    `ARCR_OFF_CMP_LOW:
                        s_axi_rdata <= {24'h0, compare_value_low};
                    `ARCR_OFF_CONFIG: s_axi_rdata <= {24'h0,
                        low_power_select, clock_divide_select,
                        long_sample_select, conv_mode, input_clock_select};
                    `ARCR_OFF_PIN_LO:
                        s_axi_rdata <= {24'h0, analog_pin_disable_lo};
                    `ARCR_OFF_CONTROL: s_axi_rdata <= {29'h0,
                        completion_irq_enable, compare_greater_select,
                        compare_enable};
                    `ARCR_OFF_STATUS: s_axi_rdata <= {29'h0, read_lock,
                        result_valid, conversion_complete_flag};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `ARCR_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

// File: tb/arcr_regs_sva.sv
// arcr_regs_sva.sv: port-level checks on the converter register block.
// assumes it is bound to arcr_regs and sees that module's ports only.
// --------------------------------------------------------------------
// checker
// --------------------------------------------------------------------
module arcr_regs_sva (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_wvalid,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire conv_done,
    input wire [1:0] conv_mode,
    input wire [7:0] analog_pin_disable_lo,
    input wire conversion_complete_flag,
    input wire completion_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // both write channels offered while no response is pending
    sequence s_wr_offer;
        s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    endsequence
    // address grant followed by zero-extended read data
    sequence s_rd_grant;
        s_axi_arready ##1 (s_axi_rvalid && s_axi_rdata[31:8] == 24'h0);
    endsequence
    a_write_answer: assert property (s_wr_offer |=> s_axi_bvalid)
        else $error("write not answered in one cycle");
    a_read_answer: assert property (s_axi_arready |-> s_rd_grant)
        else $error("read data late or not zero-extended");
    a_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready)
        else $error("read grant longer than one cycle");
    a_b_holds: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_r_holds: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_flag_cause: assert property (
        $rose(conversion_complete_flag) |-> $past(conv_done))
        else $error("complete flag set without a conversion");
    a_irq_follows: assert property (
        completion_irq |-> conversion_complete_flag)
        else $error("interrupt without complete flag");
    a_mode_by_write: assert property (
        $changed(conv_mode) |-> $past(s_axi_wvalid))
        else $error("mode changed without a write");
    a_pin_by_write: assert property (
        $changed(analog_pin_disable_lo) |-> $past(s_axi_wvalid))
        else $error("pin disable changed without a write");
endmodule

bind arcr_regs arcr_regs_sva arcr_regs_sva_i (.aclk, .aresetn,
    .s_axi_awvalid, .s_axi_wvalid, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .conv_done, .conv_mode, .analog_pin_disable_lo,
    .conversion_complete_flag, .completion_irq);

// File: tb/arcr_core_model.sv
// arcr_core_model.sv: behavioural conversion core feeding the block.
// assumes start is a one-cycle request synchronous to aclk.
module arcr_core_model (
    input wire logic aclk,
    input wire logic start,
    input wire logic [3:0] latency,
    input wire logic [11:0] value,
    output logic [11:0] conv_result,
    output logic conv_done
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] count = 5'h00;
    logic [11:0] held = 12'h000;
    initial begin
        conv_done = 1'b0;
        conv_result = 12'h000;
    end
    // result is valid only with done; else inverted so nobody leans on it
    always @(posedge aclk) begin
        conv_done <= (count == 5'h01);
        conv_result <= (count == 5'h01) ? held : ~held;
        if (start) begin
            count <= {1'b0, latency} + 5'h01;
            held <= value;
        end else if (count != 5'h00) begin
            count <= count - 5'h01;
        end
    end
endmodule

// File: tb/tb_arcr_regs.sv
// tb_arcr_regs.sv: self-checking bench for the converter register block.
// assumes arcr_regs, its checker and the core model are compiled first.
`include "arcr_defines.vh"
module tb_arcr_regs;
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------------------------------
    // signals and instances
    // ----------------------------------------------------------------
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, start = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, low_power_select, long_sample_select, conv_done;
    logic [1:0] s_axi_bresp, s_axi_rresp, clock_divide_select, conv_mode;
    logic [1:0] input_clock_select, last_resp;
    logic conversion_complete_flag, completion_irq;
    logic [11:0] conv_result, conv_value = 12'h000;
    logic [3:0] latency = 4'h0;
    logic [7:0] analog_pin_disable_lo;
    int failures = 0, num_checks = 0, cycles = 0;
    arcr_regs arcr_regs_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .conv_result,
        .conv_done, .low_power_select, .clock_divide_select,
        .long_sample_select, .conv_mode, .input_clock_select,
        .analog_pin_disable_lo, .conversion_complete_flag, .completion_irq);
    arcr_core_model arcr_core_model_i (.aclk, .start, .latency,
        .value(conv_value), .conv_result, .conv_done);
    initial begin
        forever #50 aclk = ~aclk;
    end
    // ----------------------------------------------------------------
    // bus and compare tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // bready rises with the request and stays up until bvalid is seen
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            done = s_axi_bvalid;
            last_resp = s_axi_bresp;
        end
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp,
                      input logic [1:0] er = `ARCR_RESP_OKAY);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            done = s_axi_rvalid;
        end
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, {24'h0, exp});
        chk({30'h0, s_axi_rresp}, {30'h0, er});
    endtask
    task automatic conv(input logic [11:0] v, input logic [3:0] lat);
        @(posedge aclk);
        conv_value <= v;
        latency <= lat;
        start <= 1'b1;
        @(posedge aclk);
        start <= 1'b0;
        repeat (lat + 4) @(posedge aclk);
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        for (int i = 0; i < 8; i++) rd(i[3:0], 8'h00);
        rd(4'h8, 8'h00, `ARCR_RESP_SLVERR);
        wr(4'h9, 8'h5A);
        chk({30'h0, last_resp}, {30'h0, `ARCR_RESP_SLVERR});
        chk({22'h0, conv_mode, analog_pin_disable_lo}, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_config;
        // no entry puts the reserved code 11 in bits 3:2
        logic [7:0] tab [4] = '{8'h00, 8'h55, 8'hAA, 8'hF3};
        for (int i = 0; i < 4; i++) begin
            wr(`ARCR_OFF_CONFIG, tab[i]);
            chk({24'h0, low_power_select, clock_divide_select,
                long_sample_select, conv_mode, input_clock_select},
                {24'h0, tab[i]});
            rd(`ARCR_OFF_CONFIG, tab[i]);
        end
        wr(`ARCR_OFF_PIN_LO, 8'h5A);
        chk({24'h0, analog_pin_disable_lo}, 32'h5A);
        rd(`ARCR_OFF_PIN_LO, 8'h5A);
        wr(`ARCR_OFF_RESULT_HIGH, 8'hFF);
        rd(`ARCR_OFF_RESULT_HIGH, 8'h00);
        $display("test config done");
    endtask
    task automatic t_align;
        logic [1:0] md [3] = '{`ARCR_MODE_12, `ARCR_MODE_10, `ARCR_MODE_8};
        logic [7:0] hi [3] = '{8'h05, 8'h01, 8'h00};
        for (int i = 0; i < 3; i++) begin
            wr(`ARCR_OFF_CONFIG, {4'h0, md[i], 2'h0});
            rd(`ARCR_OFF_STATUS, 8'h00);
            conv(12'h555, (i == 1) ? 4'h9 : 4'h0);
            chk({31'h0, conversion_complete_flag}, 32'h1);
            chk({31'h0, completion_irq}, 32'h0);
            rd(`ARCR_OFF_STATUS, 8'h03);
            rd(`ARCR_OFF_RESULT_HIGH, hi[i]);
            rd(`ARCR_OFF_RESULT_LOW, 8'h55);
        end
        $display("test align done");
    endtask
    task automatic t_lock;
        wr(`ARCR_OFF_CONFIG, 8'h04);
        conv(12'h555, 4'h0);
        rd(`ARCR_OFF_RESULT_HIGH, 8'h05);
        rd(`ARCR_OFF_STATUS, 8'h07);
        conv(12'hAAA, 4'h9);
        rd(`ARCR_OFF_RESULT_LOW, 8'h55);
        conv(12'hAAA, 4'h0);
        rd(`ARCR_OFF_RESULT_HIGH, 8'h0A);
        rd(`ARCR_OFF_RESULT_LOW, 8'hAA);
        wr(`ARCR_OFF_CONFIG, 8'h00);
        conv(12'h555, 4'h0);
        rd(`ARCR_OFF_RESULT_HIGH, 8'h00);
        conv(12'h333, 4'h0);
        rd(`ARCR_OFF_RESULT_LOW, 8'h33);
        $display("test lock done");
    endtask
    // each step: control, value, expected low (and high in 12- and 10-bit) after it
    task automatic t_cmp;
        wr(`ARCR_OFF_CMP_LOW, 8'h40);
        wr(`ARCR_OFF_CMP_HIGH, 8'h0F);
        wr(`ARCR_OFF_CONTROL, 8'h00);
        conv(12'h555, 4'h0);
        rd(`ARCR_OFF_RESULT_LOW, 8'h55);
        wr(`ARCR_OFF_CONTROL, 8'h01);
        conv(12'h333, 4'h0);
        rd(`ARCR_OFF_RESULT_LOW, 8'h33);
        conv(12'h555, 4'h0);
        rd(`ARCR_OFF_RESULT_LOW, 8'h33);
        wr(`ARCR_OFF_CONTROL, 8'h03);
        conv(12'h555, 4'h0);
        rd(`ARCR_OFF_RESULT_LOW, 8'h55);
        wr(`ARCR_OFF_CONFIG, 8'h04);
        wr(`ARCR_OFF_CMP_HIGH, 8'h0B);
        wr(`ARCR_OFF_CMP_LOW, 8'h00);
        wr(`ARCR_OFF_CONTROL, 8'h01);
        conv(12'hAAA, 4'h0);
        rd(`ARCR_OFF_RESULT_HIGH, 8'h0A);
        rd(`ARCR_OFF_RESULT_LOW, 8'hAA);
        wr(`ARCR_OFF_CONTROL, 8'h03);
        conv(12'h555, 4'h0);
        rd(`ARCR_OFF_RESULT_HIGH, 8'h0A);
        rd(`ARCR_OFF_RESULT_LOW, 8'hAA);
        wr(`ARCR_OFF_CONFIG, 8'h08);
        wr(`ARCR_OFF_CMP_HIGH, 8'h05);
        wr(`ARCR_OFF_CONTROL, 8'h07);
        conv(12'h555, 4'h9);
        chk({31'h0, completion_irq}, 32'h1);
        rd(`ARCR_OFF_RESULT_HIGH, 8'h01);
        rd(`ARCR_OFF_RESULT_LOW, 8'h55);
        @(posedge aclk);
        chk({31'h0, completion_irq}, 32'h0);
        $display("test compare done");
    endtask
    // ----------------------------------------------------------------
    // sequence, hang guard and verdict
    // ----------------------------------------------------------------
    task automatic end_of_test;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // the whole run needs a few hundred cycles; this cuts a hang short
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            end_of_test();
        end
    end
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_config();
        t_align();
        t_lock();
        t_cmp();
        end_of_test();
    end
endmodule
